/* hw/uii_top.sv */
// Interrupt prioritising and identification for a serial port, APB slave.
// Assumes all event pulses and FIFO counts come from logic on pclk;
// only the modem pins arrive asynchronously.
`timescale 1ns/10ps
`include "uii_cfg.svh"
module uii_top
  import uii_pkg::*;
#(
  parameter int FILL_W = 5
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata_q,
  output logic pready_q,
  output logic pslverr_q,
  input wire uii_line_err_t line_err,
  input wire logic line_status_read,
  input wire logic [FILL_W-1:0] rx_fill,
  input wire logic rx_write,
  input wire logic rx_buffer_read,
  input wire logic sample_tick,
  input wire logic [3:0] word_bits,
  input wire logic [FILL_W-1:0] tx_fill,
  input wire logic tx_holding_write,
  input wire uii_modem_t modem_pins,
  input wire logic modem_status_read,
  input wire logic autobaud_done,
  input wire logic autobaud_timeout,
  output logic fifo_on_q,
  output logic [1:0] rx_trigger_sel_q
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [9:0] enable_q;
  logic [7:0] fifoctl_q;
  logic line_fault_q;
  logic tx_holding_empty_irq_q;
  logic modem_q;
  logic ab_done_q;
  logic ab_timeout_q;
  logic idle_timeout;
  uii_modem_t mdm_meta_q;
  uii_modem_t mdm_sync_q;
  uii_modem_t mdm_prev_q;
  uii_tx_holding_empty_irq_state_t thr_state_q;
  logic [15:0] thr_count_q;
  logic two_held_q;
  uii_code_t snap_code_q;
  logic snap_pend_n_q;
  logic setup_cyc;
  logic access_done;
  logic wr_done;
  logic ident_rd_done;
  logic [31:0] ident_word;
  logic [31:0] read_word;
  logic addr_hit;
  uii_code_t code_d;
  logic pend_n_d;
  logic [FILL_W-1:0] trig_level;
  logic rx_level_reached;
  logic [FILL_W-1:0] trig_gap;
  logic [15:0] idle_limit;
  logic [15:0] thr_limit;
  logic modem_event;
  logic tx_empty;
  logic tx_holding_empty_irq_clear;

  ////////////////////////////////////////////////////////////////////////////
  // APB phase decode

  // Setup cycle and completed access
  assign setup_cyc = psel && !penable;
  assign access_done = psel && penable && pready_q;
  assign wr_done = access_done && pwrite;
  assign ident_rd_done = access_done && !pwrite &&
                         (paddr == `UII_ADDR_IDENT);

  // Address decode for every mapped register
  always_comb begin
    addr_hit = 1'b0;
    case (paddr)
      `UII_ADDR_ENABLE: addr_hit = 1'b1;
      `UII_ADDR_IDENT: addr_hit = 1'b1;
      `UII_ADDR_FIFOCTL: addr_hit = 1'b1;
      `UII_ADDR_ABCLR: addr_hit = 1'b1;
      `UII_ADDR_RAW: addr_hit = 1'b1;
      default: addr_hit = 1'b0;
    endcase
  end

  // One wait-free answer, ready in the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= setup_cyc;
    end
  end

  // Unmapped addresses answer with an error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_q <= 1'b0;
    end else begin
      pslverr_q <= setup_cyc && !addr_hit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software registers

  // Interrupt enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_q <= `UII_ENABLE_RESET;
    end else if (wr_done && paddr == `UII_ADDR_ENABLE) begin
      enable_q <= pwdata[9:0] & `UII_ENABLE_MASK;
    end
  end

  // FIFO enable and trigger select
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fifoctl_q <= `UII_FIFOCTL_RESET;
    end else if (wr_done && paddr == `UII_ADDR_FIFOCTL) begin
      fifoctl_q <= {pwdata[7:6], 5'h00, pwdata[0]};
    end
  end

  // FIFO settings passed on to the surrounding port
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fifo_on_q <= 1'b0;
      rx_trigger_sel_q <= 2'h0;
    end else begin
      fifo_on_q <= fifoctl_q[`UII_FC_FIFO_ON];
      rx_trigger_sel_q <= fifoctl_q[`UII_FC_TRIG_LSB +: 2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive sources

  // Trigger level from the FIFO control field
  always_comb begin
    trig_level = `UII_TRIG_L0;
    case (fifoctl_q[`UII_FC_TRIG_LSB +: 2])
      2'h0: trig_level = `UII_TRIG_L0;
      2'h1: trig_level = `UII_TRIG_L1;
      2'h2: trig_level = `UII_TRIG_L2;
      2'h3: trig_level = `UII_TRIG_L3;
      default: trig_level = `UII_TRIG_L0;
    endcase
  end

  // Level source follows the fill directly
  assign rx_level_reached = (rx_fill >= trig_level);

  // Idle limit from word length, trigger and held characters
  assign trig_gap = (trig_level > rx_fill) ? trig_level - rx_fill : '0;
  assign idle_limit = 16'(({12'h000, word_bits} * `UII_TO_CHAR_MULT -
                           `UII_TO_CHAR_SUB) * `UII_TO_STEP) +
                      16'({{(16-FILL_W){1'b0}}, trig_gap} * `UII_TO_STEP +
                          `UII_TO_BIAS);

  // Idle time-out timer
  uii_idle_timer #(
    .CW(16)
  ) u_idle_timer (
    .pclk(pclk),
    .presetn(presetn),
    .sample_tick(sample_tick),
    .fifo_activity(rx_write || rx_buffer_read),
    .fifo_nonempty(rx_fill != '0),
    .limit(idle_limit),
    .timeout_q(idle_timeout)
  );

  // Line fault flag; a new error beats a clearing read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_fault_q <= 1'b0;
    end else if (|line_err) begin
      line_fault_q <= 1'b1;
    end else if (line_status_read) begin
      line_fault_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit empty source

  assign tx_empty = (tx_fill == '0);
  assign thr_limit = 16'(({12'h000, word_bits} + 16'h0001) *
                         `UII_TICKS_PER_BIT);
  assign tx_holding_empty_irq_clear = tx_holding_write ||
                      (ident_rd_done && !snap_pend_n_q &&
                       snap_code_q == `UII_CODE_TX_HOLDING_EMPTY_IRQ);

  // Remember two characters held since the last empty event
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      two_held_q <= 1'b0;
    end else if (tx_fill >= FILL_W'(2)) begin
      two_held_q <= 1'b1;
    end else if (thr_state_q == THR_EMPTY) begin
      two_held_q <= 1'b0;
    end
  end

  // Empty delay sequence
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      thr_state_q <= THR_BUSY;
      thr_count_q <= 16'h0000;
    end else begin
      case (thr_state_q)
        THR_BUSY: begin
          thr_count_q <= 16'h0000;
          if (tx_empty) begin
            thr_state_q <= two_held_q ? THR_EMPTY : THR_DELAY;
          end
        end
        THR_DELAY: begin
          if (!tx_empty) begin
            thr_state_q <= THR_BUSY;
          end else if (thr_count_q >= thr_limit) begin
            thr_state_q <= THR_EMPTY;
          end else if (sample_tick) begin
            thr_count_q <= thr_count_q + 16'h0001;
          end
        end
        THR_EMPTY: begin
          if (!tx_empty) begin
            thr_state_q <= THR_BUSY;
          end
        end
        default: begin
          thr_state_q <= THR_BUSY;
        end
      endcase
    end
  end

  // Flag raised on entry to empty; raise beats clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_holding_empty_irq_q <= 1'b0;
    end else if (tx_empty && ((thr_state_q == THR_BUSY && two_held_q) ||
                 (thr_state_q == THR_DELAY && thr_count_q >= thr_limit))) begin
      tx_holding_empty_irq_q <= 1'b1;
    end else if (tx_holding_empty_irq_clear || !tx_empty) begin
      tx_holding_empty_irq_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Modem source

  // Two-flop synchroniser plus a history stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mdm_meta_q <= '0;
      mdm_sync_q <= '0;
      mdm_prev_q <= '0;
    end else begin
      mdm_meta_q <= modem_pins;
      mdm_sync_q <= mdm_meta_q;
      mdm_prev_q <= mdm_sync_q;
    end
  end

  assign modem_event = (mdm_sync_q.dcd != mdm_prev_q.dcd) ||
                       (mdm_sync_q.dsr != mdm_prev_q.dsr) ||
                       (mdm_sync_q.cts != mdm_prev_q.cts) ||
                       (mdm_sync_q.ri && !mdm_prev_q.ri);

  // Modem flag; a pin change (for ring, a rise only) beats the clearing read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      modem_q <= 1'b0;
    end else if (modem_event) begin
      modem_q <= 1'b1;
    end else if (modem_status_read) begin
      modem_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Auto-baud flags

  // Set by the auto-baud unit, cleared by writing the clear bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ab_done_q <= 1'b0;
    end else if (autobaud_done) begin
      ab_done_q <= 1'b1;
    end else if (wr_done && paddr == `UII_ADDR_ABCLR &&
                 pwdata[`UII_ID_ABEO]) begin
      ab_done_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ab_timeout_q <= 1'b0;
    end else if (autobaud_timeout) begin
      ab_timeout_q <= 1'b1;
    end else if (wr_done && paddr == `UII_ADDR_ABCLR &&
                 pwdata[`UII_ID_ABTO]) begin
      ab_timeout_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Priority encoder and identification word

  // Highest enabled source wins
  always_comb begin
    code_d = `UII_CODE_MODEM;
    pend_n_d = 1'b1;
    if (line_fault_q && enable_q[`UII_EN_LINE]) begin
      code_d = `UII_CODE_LINE;
      pend_n_d = 1'b0;
    end else if (rx_level_reached && enable_q[`UII_EN_RXDATA]) begin
      code_d = `UII_CODE_RXDATA;
      pend_n_d = 1'b0;
    end else if (idle_timeout && enable_q[`UII_EN_RXDATA]) begin
      code_d = `UII_CODE_IDLE;
      pend_n_d = 1'b0;
    end else if (tx_holding_empty_irq_q && enable_q[`UII_EN_TX_HOLDING_EMPTY_IRQ]) begin
      code_d = `UII_CODE_TX_HOLDING_EMPTY_IRQ;
      pend_n_d = 1'b0;
    end else if (modem_q && enable_q[`UII_EN_MODEM]) begin
      code_d = `UII_CODE_MODEM;
      pend_n_d = 1'b0;
    end else begin
      code_d = `UII_CODE_MODEM;
      pend_n_d = 1'b1;
    end
  end

  // Assemble the word; reserved bits read zero
  always_comb begin
    ident_word = 32'h0000_0000;
    ident_word[`UII_ID_PEND] = pend_n_d;
    ident_word[`UII_ID_CODE_LSB +: 3] = code_d;
    ident_word[`UII_ID_FIFO_LO] = fifoctl_q[`UII_FC_FIFO_ON];
    ident_word[`UII_ID_FIFO_HI] = fifoctl_q[`UII_FC_FIFO_ON];
    ident_word[`UII_ID_ABEO] = ab_done_q && enable_q[`UII_EN_ABEO];
    ident_word[`UII_ID_ABTO] = ab_timeout_q &&
                               enable_q[`UII_EN_ABTO];
  end

  // Read data mux
  always_comb begin
    read_word = 32'h0000_0000;
    case (paddr)
      `UII_ADDR_ENABLE: read_word = {22'h000000, enable_q};
      `UII_ADDR_IDENT: read_word = ident_word;
      `UII_ADDR_FIFOCTL: read_word = {24'h000000, fifoctl_q};
      `UII_ADDR_RAW: read_word = {25'h0000000, ab_timeout_q, ab_done_q,
                                  modem_q, tx_holding_empty_irq_q, idle_timeout,
                                  rx_level_reached, line_fault_q};
      default: read_word = 32'h0000_0000;
    endcase
  end

  // Sample the word once at setup and hold it through the access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= `UII_IDENT_RESET;
    end else if (setup_cyc && !pwrite) begin
      prdata_q <= read_word;
    end
  end

  // Frozen code used to decide the transmit empty clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      snap_code_q <= `UII_CODE_MODEM;
      snap_pend_n_q <= 1'b1;
    end else if (setup_cyc && !pwrite && paddr == `UII_ADDR_IDENT) begin
      snap_code_q <= code_d;
      snap_pend_n_q <= pend_n_d;
    end
  end

endmodule : uii_top

/* hw/uii_cfg.svh */
// Constants for the serial-port interrupt identification block.
// Assumes inclusion by bare name from the package and the modules.
`ifndef UII_CFG_SVH
`define UII_CFG_SVH

// Register byte addresses on APB
`define UII_ADDR_ENABLE 32'h4004_8004
`define UII_ADDR_IDENT 32'h4004_8008
`define UII_ADDR_FIFOCTL 32'h4004_800c
`define UII_ADDR_ABCLR 32'h4004_8010
`define UII_ADDR_RAW 32'h4004_8014

// Identification register fields
`define UII_ID_PEND 0
`define UII_ID_CODE_LSB 1
`define UII_ID_FIFO_LO 6
`define UII_ID_FIFO_HI 7
`define UII_ID_ABEO 8
`define UII_ID_ABTO 9

// Enable register fields
`define UII_EN_RXDATA 0
`define UII_EN_TX_HOLDING_EMPTY_IRQ 1
`define UII_EN_LINE 2
`define UII_EN_MODEM 3
`define UII_EN_ABEO 8
`define UII_EN_ABTO 9
`define UII_ENABLE_MASK 10'h30f

// FIFO control fields
`define UII_FC_FIFO_ON 0
`define UII_FC_TRIG_LSB 6

// Source codes
`define UII_CODE_LINE 3'h3
`define UII_CODE_RXDATA 3'h2
`define UII_CODE_IDLE 3'h6
`define UII_CODE_TX_HOLDING_EMPTY_IRQ 3'h1
`define UII_CODE_MODEM 3'h0

// Reset values
`define UII_IDENT_RESET 32'h0000_0001
`define UII_ENABLE_RESET 10'h000
`define UII_FIFOCTL_RESET 8'h00

// Receive trigger levels selected by the FIFO control field
`define UII_TRIG_L0 5'h01
`define UII_TRIG_L1 5'h04
`define UII_TRIG_L2 5'h08
`define UII_TRIG_L3 5'h0e

// Character time-out arithmetic, in receive sampling clocks
`define UII_TO_CHAR_MULT 16'h0007
`define UII_TO_CHAR_SUB 16'h0002
`define UII_TO_STEP 16'h0008
`define UII_TO_BIAS 16'h0001

// Sampling clocks per bit, for the transmit empty delay
`define UII_TICKS_PER_BIT 16'h0010

`endif

/* hw/uii_pkg.sv */
// Types for the serial-port interrupt identification block.
// Assumes uii_cfg.svh is on the include path.
package uii_pkg;
  `include "uii_cfg.svh"

  // Receive line error events, one-cycle pulses
  typedef struct packed {
    logic overrun;
    logic parity_err;
    logic framing_err;
    logic break_seen;
  } uii_line_err_t;

  // Modem input pins
  typedef struct packed {
    logic dcd;
    logic dsr;
    logic cts;
    logic ri;
  } uii_modem_t;

  // Transmit empty delay states
  typedef enum logic [2:0] {
    THR_BUSY = 3'b001,
    THR_DELAY = 3'b010,
    THR_EMPTY = 3'b100
  } uii_tx_holding_empty_irq_state_t;

  typedef logic [2:0] uii_code_t;
endpackage : uii_pkg

/* hw/uii_idle_timer.sv */
// Receive idle timer raising the character time-out flag.
// Assumes sample_tick and activity come from logic on pclk.
`timescale 1ns/10ps
module uii_idle_timer
  import uii_pkg::*;
#(
  parameter int CW = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sample_tick,
  input wire logic fifo_activity,
  input wire logic fifo_nonempty,
  input wire logic [CW-1:0] limit,
  output logic timeout_q
);

  logic [CW-1:0] count_q;

  // Count sampling clocks since the last FIFO activity
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= '0;
    end else if (fifo_activity || !fifo_nonempty) begin
      count_q <= '0;
    end else if (sample_tick && !timeout_q) begin
      count_q <= count_q + 1'b1;
    end
  end

  // Flag fires on the exact count, any activity drops it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timeout_q <= 1'b0;
    end else if (fifo_activity || !fifo_nonempty) begin
      timeout_q <= 1'b0;
    end else if (sample_tick && (count_q + 1'b1 == limit)) begin
      timeout_q <= 1'b1;
    end
  end
endmodule : uii_idle_timer

/* verification/uii_top_properties.sv */
// Port-level checks for the interrupt identification block.
// Assumes a bind from the bench top and uii_cfg.svh on the include path.
`timescale 1ns/10ps
`include "uii_cfg.svh"
module uii_top_properties
  import uii_pkg::*;
#(
  parameter int FILL_W = 5
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata_q,
  input wire logic pready_q,
  input wire logic pslverr_q,
  input wire uii_line_err_t line_err,
  input wire logic line_status_read,
  input wire logic fifo_on_q
);
  logic setup, acc_wr, rd_id, bad_addr, fc_q, line_q;
  logic [9:0] en_q;

  // Bus phase decode
  assign setup = psel && !penable;
  assign acc_wr = psel && penable && pready_q && pwrite;
  assign rd_id = setup && !pwrite && paddr == `UII_ADDR_IDENT;
  assign bad_addr = !(paddr inside {`UII_ADDR_ENABLE, `UII_ADDR_IDENT,
    `UII_ADDR_FIFOCTL, `UII_ADDR_ABCLR, `UII_ADDR_RAW});

  // Shadows of enables, FIFO switch and line fault flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q <= 10'h000;
      fc_q <= 1'b0;
      line_q <= 1'b0;
    end else begin
      if (acc_wr && paddr == `UII_ADDR_ENABLE) begin
        en_q <= pwdata[9:0] & `UII_ENABLE_MASK;
      end
      if (acc_wr && paddr == `UII_ADDR_FIFOCTL) begin
        fc_q <= pwdata[0];
      end
      if (|line_err) begin
        line_q <= 1'b1; // Set wins over clear
      end else if (line_status_read) begin
        line_q <= 1'b0;
      end
    end
  end

  //////////////////////////////
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_ready;
    setup |=> pready_q;
  endproperty
  a_ready: assert property (p_ready) else $error("No ready after setup");
  property p_pulse;
    pready_q |=> !pready_q;
  endproperty
  a_pulse: assert property (p_pulse) else $error("Ready held too long");
  property p_err;
    setup |=> pslverr_q == $past(bad_addr);
  endproperty
  a_err: assert property (p_err) else $error("Wrong slave error");
  property p_fifo;
    acc_wr && paddr == `UII_ADDR_FIFOCTL |-> ##[1:2] fifo_on_q == fc_q;
  endproperty
  a_fifo: assert property (p_fifo) else $error("FIFO switch lost");
  property p_resv;
    rd_id |=> prdata_q[7:6] == {2{$past(fc_q)}} && prdata_q[5:4] == 2'b00
      && prdata_q[31:10] == 22'h0;
  endproperty
  a_resv: assert property (p_resv) else $error("Bad upper bits");
  property p_code;
    rd_id ##1 !prdata_q[0] |-> !(prdata_q[3:1] inside {3'h4, 3'h5, 3'h7});
  endproperty
  a_code: assert property (p_code) else $error("Reserved code");
  property p_none;
    rd_id ##1 prdata_q[0] |-> prdata_q[3:1] == 3'h0;
  endproperty
  a_none: assert property (p_none) else $error("Code without pend");
  property p_abeo;
    rd_id |=> !prdata_q[8] || en_q[8];
  endproperty
  a_abeo: assert property (p_abeo) else $error("Done bit unmasked");
  property p_abto;
    rd_id && !en_q[9] |=> !prdata_q[9];
  endproperty
  a_abto: assert property (p_abto) else $error("Timeout unmasked");
  property p_line;
    rd_id && line_q && en_q[2] |=> prdata_q[3:0] == 4'h6;
  endproperty
  a_line: assert property (p_line) else $error("Line fault hidden");

  // Main scenarios reached
  c_idle: cover property (rd_id ##1 prdata_q[3:0] == 4'hc);
  c_tx_holding_empty_irq: cover property (rd_id ##1 prdata_q[3:0] == 4'h2);
  c_abeo: cover property (rd_id ##1 prdata_q[8]);
  c_err: cover property (pslverr_q);
endmodule : uii_top_properties

/* verification/uii_cpu_model.sv */
// Processor model: APB master, service routine and clear strobes.
// Assumes the bench calls its tasks one at a time.
`timescale 1ns/10ps
`include "uii_cfg.svh"
module uii_cpu_model (
  input wire logic pclk,
  input wire logic pready_q,
  input wire logic pslverr_q,
  input wire logic [31:0] prdata_q,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [31:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] clr_q,
  output logic hung
);
  // Idle bus at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    clr_q = 4'h0;
    hung = 1'b0;
  end

  // One transfer; released address and data lines show the inverse of their last value
  task automatic xfer(input logic w, input logic [31:0] a,
      input logic [31:0] d, output logic [32:0] re);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready_q !== 1'b1 && n < 64);
    hung <= (pready_q !== 1'b1);
    re = {pslverr_q, prdata_q};
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask : xfer

  // One-cycle strobe: line status, rx buffer, modem status, tx holding
  task automatic pulse(input int k);
    @(posedge pclk);
    clr_q[k] <= 1'b1;
    @(posedge pclk);
    clr_q[k] <= 1'b0;
  endtask : pulse

  // Read the cause, then take its clearing action
  task automatic service();
    logic [32:0] re;
    xfer(1'b0, `UII_ADDR_IDENT, 32'h0, re);
    if (re[0] == 1'b0) begin
      case (re[3:1])
        `UII_CODE_LINE: pulse(0);
        `UII_CODE_RXDATA, `UII_CODE_IDLE: pulse(1);
        `UII_CODE_MODEM: pulse(2);
        default: ; // Transmit empty clears by the read itself
      endcase
    end
  endtask : service
endmodule : uii_cpu_model

/* verification/uii_top_bench.sv */
// Self-checking bench for the interrupt identification block.
// Assumes uii_cfg.svh on the include path; the processor model owns APB.
`timescale 1ns/10ps
`include "uii_cfg.svh"
module uii_top_bench
  import uii_pkg::*;
  ;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready_q, pslverr_q, fifo_on_q, hung;
  logic [31:0] paddr, pwdata, prdata_q;
  logic [1:0] rx_trigger_sel_q;
  logic [3:0] clr_q, word_bits;
  logic [4:0] rx_fill, tx_fill;
  logic rx_write, sample_tick, autobaud_done, autobaud_timeout;
  uii_line_err_t line_err;
  uii_modem_t modem_pins;
  int err_total = 0;
  int comparisons = 0;
  integer seed = 32'h83ae;

  // 200 MHz clock
  always #2.5 pclk = ~pclk;

  uii_top #(.FILL_W(5)) dut_u (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata_q, .pready_q, .pslverr_q,
    .line_err, .line_status_read(clr_q[0]), .rx_fill, .rx_write,
    .rx_buffer_read(clr_q[1]), .sample_tick, .word_bits, .tx_fill,
    .tx_holding_write(clr_q[3]), .modem_pins,
    .modem_status_read(clr_q[2]), .autobaud_done, .autobaud_timeout,
    .fifo_on_q, .rx_trigger_sel_q);

  uii_cpu_model cpu_u (.pclk, .pready_q, .pslverr_q, .prdata_q, .psel,
    .penable, .pwrite, .paddr, .pwdata, .clr_q, .hung);

  //////////////////////////////
  task automatic close_out();
    $display("Comparisons %0d, errors %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // A stuck transfer ends the run
  always @(posedge pclk) begin
    if (hung === 1'b1) begin
      err_total++;
      close_out();
    end
  end

  task automatic rdc(input logic [31:0] a, input logic [32:0] x);
    logic [32:0] re;
    cpu_u.xfer(1'b0, a, 32'h0, re);
    chk(re, x);
  endtask : rdc

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [32:0] re;
    cpu_u.xfer(1'b1, a, d, re);
  endtask : wr

  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask : wt

  // Expected identification word with the FIFOs switched on
  function automatic logic [32:0] idv(input logic pend,
      input logic [2:0] code, input logic [1:0] ab);
    logic [3:0] lo;
    lo = pend ? {code, 1'b0} : 4'h1;
    return {1'b0, 22'h0, ab, 2'b11, 2'b00, lo};
  endfunction : idv

  function automatic int idle_n(input int wb, input int lvl, input int n);
    return (wb * 7 - 2) * 8 + (lvl - n) * 8 + 1;
  endfunction : idle_n

  // Receive trigger level for each FIFO control select value
  function automatic logic [4:0] trig_of(input int s);
    case (s)
      0: return `UII_TRIG_L0;
      1: return `UII_TRIG_L1;
      2: return `UII_TRIG_L2;
      default: return `UII_TRIG_L3;
    endcase
  endfunction : trig_of

  //////////////////////////////
  initial begin
    line_err = '0;
    rx_fill = 5'h00;
    tx_fill = 5'h03;
    rx_write = 1'b0;
    sample_tick = 1'b0;
    word_bits = 4'h8;
    modem_pins = '0;
    autobaud_done = 1'b0;
    autobaud_timeout = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rdc(`UII_ADDR_IDENT, {1'b0, `UII_IDENT_RESET});
    rdc(`UII_ADDR_ENABLE, 33'h0);
    rdc(`UII_ADDR_FIFOCTL, 33'h0);
    rdc(32'h4004_8018, 33'h1_0000_0000);
    wr(`UII_ADDR_FIFOCTL, 32'h41);
    wr(`UII_ADDR_ENABLE, 32'h30f);
    chk({30'h0, rx_trigger_sel_q, fifo_on_q}, 33'h3);
    rdc(`UII_ADDR_IDENT, idv(0, 0, 0));
    // Line faults over a receive FIFO at its trigger level, every error kind
    rx_fill <= 5'h04;
    for (int i = 0; i < 4; i++) begin
      line_err <= uii_line_err_t'(4'(1 << i) | 4'($random(seed)));
      @(posedge pclk);
      line_err <= '0;
      rdc(`UII_ADDR_IDENT, idv(1, `UII_CODE_LINE, 0));
      cpu_u.service();
      rdc(`UII_ADDR_IDENT, idv(1, `UII_CODE_RXDATA, 0));
    end
    rx_fill <= 5'h03;
    rdc(`UII_ADDR_IDENT, idv(0, 0, 0));
    // Event during a read shows on the next one
    fork
      rdc(`UII_ADDR_IDENT, idv(0, 0, 0));
      begin
        wt(2);
        line_err <= uii_line_err_t'(4'h8);
        wt(1);
        line_err <= '0;
      end
    join
    rdc(`UII_ADDR_IDENT, idv(1, `UII_CODE_LINE, 0));
    cpu_u.service();
    // Idle time-out with a random word length
    word_bits <= 4'h5 + 4'($unsigned($random(seed)) % 4);
    rx_fill <= 5'h02;
    rx_write <= 1'b1;
    sample_tick <= 1'b1;
    @(posedge pclk);
    rx_write <= 1'b0;
    wt(idle_n(word_bits, 4, 2) - 8);
    rdc(`UII_ADDR_IDENT, idv(0, 0, 0));
    wt(8);
    rdc(`UII_ADDR_IDENT, idv(1, `UII_CODE_IDLE, 0));
    cpu_u.service();
    rdc(`UII_ADDR_IDENT, idv(0, 0, 0));
    rx_fill <= 5'h00;
    // Transmit empty: at once, then delayed
    tx_fill <= 5'h00;
    wt(2);
    rdc(`UII_ADDR_IDENT, idv(1, `UII_CODE_TX_HOLDING_EMPTY_IRQ, 0));
    rdc(`UII_ADDR_IDENT, idv(0, 0, 0));
    tx_fill <= 5'h01;
    wt(2);
    tx_fill <= 5'h00;
    rdc(`UII_ADDR_IDENT, idv(0, 0, 0));
    wt((word_bits + 1) * 16 + 4);
    rdc(`UII_ADDR_RAW, 33'h0_0000_0008);
    cpu_u.pulse(3);
    rdc(`UII_ADDR_IDENT, idv(0, 0, 0));
    tx_fill <= 5'h01;
    // Modem pins: each changes both ways; ring only counts rising
    for (int k = 0; k < 4; k++) begin
      for (int j = 0; j < 2; j++) begin
        modem_pins[k] <= ~modem_pins[k];
        wt(6);
        rdc(`UII_ADDR_IDENT, idv(k != 0 || j == 0, `UII_CODE_MODEM, 0));
        cpu_u.service();
      end
    end
    // Every trigger level: one below it quiet, at it data available
    for (int s = 0; s < 4; s++) begin
      wr(`UII_ADDR_FIFOCTL, {24'h0, 2'(s), 6'h01});
      rx_fill <= trig_of(s) - 5'h01;
      rdc(`UII_ADDR_IDENT, idv(0, 0, 0));
      rx_fill <= trig_of(s);
      rdc(`UII_ADDR_IDENT, idv(1, `UII_CODE_RXDATA, 0));
    end
    rx_fill <= 5'h00;
    // Auto-baud flags, masked and cleared
    for (int b = 0; b < 2; b++) begin
      autobaud_done <= (b == 0);
      autobaud_timeout <= (b == 1);
      @(posedge pclk);
      autobaud_done <= 1'b0;
      autobaud_timeout <= 1'b0;
      rdc(`UII_ADDR_IDENT, idv(0, 0, 2'b01 << b));
      wr(`UII_ADDR_ABCLR, 32'h100 << b);
      rdc(`UII_ADDR_IDENT, idv(0, 0, 0));
    end
    wr(`UII_ADDR_ENABLE, 32'h00f);
    autobaud_done <= 1'b1;
    autobaud_timeout <= 1'b1;
    @(posedge pclk);
    autobaud_done <= 1'b0;
    autobaud_timeout <= 1'b0;
    rdc(`UII_ADDR_IDENT, idv(0, 0, 0));
    wr(`UII_ADDR_ENABLE, 32'h30f);
    rdc(`UII_ADDR_IDENT, idv(0, 0, 2'b11));
    wr(`UII_ADDR_ABCLR, 32'h300);
    rdc(`UII_ADDR_IDENT, idv(0, 0, 0));
    rdc(`UII_ADDR_ABCLR, 33'h0);
    close_out();
  end
endmodule : uii_top_bench

bind uii_top uii_top_properties #(.FILL_W(FILL_W)) chk_u (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .pwdata, .prdata_q, .pready_q,
  .pslverr_q, .line_err, .line_status_read, .fifo_on_q);
